// ---- test/pwl_host_model.sv ----
// Host controller model driving the APB side of the lock gate
module pwl_host_model (
   // Clock
   input wire logic ref_clk,
   // Slave answer
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   // Master request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata
);
   timeunit 1ns;
   timeprecision 1ps;
   int lost = 0;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // Request held until pready is sampled high; a stuck slave is counted, not waited on forever
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) lost++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// ---- test/pwl_lock_gate_sva.sv ----
// Port checker for the lock gate
module pwl_lock_gate_sva
   import pwl_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Settings and hard reset
   input wire logic nvUserSet,
   input wire logic nvLevelMax,
   input wire logic hardReset,
   // Results
   input wire logic cmdDone,
   input wire logic cmdAborted,
   input wire logic eraseStart,
   input wire logic irq
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic cmdWr;
   assign cmdWr = psel && penable && pready && pwrite && paddr == OFS_CMD;
   AST_READY_SLOT: assert property (psel && !penable |-> ##2 pready) else $error("pready late"); // wait state
   AST_READY_CAUSE: assert property (pready |-> $past(psel && penable)) else $error("pready unasked");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready) else $error("pslverr alone");
   AST_ABORT_WITH_DONE: assert property (cmdAborted |-> cmdDone) else $error("abort alone");
   AST_DONE_FROM_CMD: assert property (cmdDone |-> $past(cmdWr, 3)) else $error("stray done");
   AST_ERASE_CLEAN: assert property (eraseStart |-> cmdDone && !cmdAborted) else $error("bad erase");
   AST_ERASE_OPCODE: assert property (eraseStart |-> $past(cmdWr && pwdata[7:0] == OP_ERASE_UNIT, 3))
      else $error("erase from other opcode");
   // Long transfer refused in every mode
   AST_LONG_RW_ABORT: assert property ((cmdWr && pwdata[10] && pwdata[15:12] == SCT_LONG_RW) ##3 cmdDone
      |-> cmdAborted) else $error("long transfer ran");
   COV_ABORT: cover property (cmdAborted);
   COV_ERASE: cover property (eraseStart);
   COV_SLVERR: cover property (pslverr);
   COV_IRQ: cover property (irq);
endmodule
bind pwl_lock_gate pwl_lock_gate_sva chk_i (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .nvUserSet(nvUserSet), .nvLevelMax(nvLevelMax), .hardReset(hardReset), .cmdDone(cmdDone),
   .cmdAborted(cmdAborted), .eraseStart(eraseStart), .irq(irq));

// ---- test/test_password_lock_command_gate.sv ----
// Self-checking bench for the lock gate
module test_password_lock_command_gate
   import pwl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, nvUserSet, nvLevelMax, hardReset;
   logic cmdDone, cmdAborted, eraseStart, irq, e, erased;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   int num_errors = 0;
   int checks_done = 0;
   // Bit 16 is the expected abort, bits 15:0 the command word
   localparam logic [16:0] LOCK_T [18] = '{17'h100C8, 17'h10035, 17'h100E7, 17'h10092, 17'h100F9, 17'h100F5,
      17'h100F1, 17'h100F6, 17'h114B0, 17'h124B0, 17'h004B0, 17'h000EC, 17'h000E4, 17'h0002F, 17'h000F8,
      17'h00070, 17'h000EF, 17'h000F3};
   localparam logic [16:0] UNL_T [5] = '{17'h114B0, 17'h000C8, 17'h000F9, 17'h024B0, 17'h000E7};
   localparam logic [16:0] FRZ_T [9] = '{17'h100F2, 17'h100F1, 17'h100F3, 17'h100F4, 17'h100F6, 17'h114B0,
      17'h000C8, 17'h000F5, 17'h000F9};
   pwl_lock_gate uut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .nvUserSet(nvUserSet), .nvLevelMax(nvLevelMax), .hardReset(hardReset), .cmdDone(cmdDone),
      .cmdAborted(cmdAborted), .eraseStart(eraseStart), .irq(irq));
   pwl_host_model host (.ref_clk(ref_clk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      checks_done++;
      if (g !== x) begin
         num_errors++;
         $display("mismatch t=%0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, q, e);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
      host.xfer(1'b0, a, 32'h0, q, e);
      chk(q & m, x);
   endtask
   // Decision pulse is looked at on the falling edge, clear of the launching edge
   task automatic cmd(input logic [15:0] w, input logic ab);
      int n;
      wr(OFS_CMD, {16'h0000, w});
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (cmdDone !== 1'b1 && n < 20);
      chk({30'h0, cmdDone, cmdAborted}, {30'h0, 1'b1, ab});
      erased = eraseStart;
   endtask
   task automatic boot(input logic us, input logic lm);
      @(posedge ref_clk);
      rst_n <= 1'b0;
      nvUserSet <= us;
      nvLevelMax <= lm;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic pulse_hard();
      @(posedge ref_clk);
      hardReset <= 1'b1;
      @(posedge ref_clk);
      hardReset <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic close_out();
      num_errors += host.lost;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      close_out();
   end
   initial begin
      rst_n = 1'b0;
      nvUserSet = 1'b1;
      nvLevelMax = 1'b1;
      hardReset = 1'b0;
      erased = 1'b0;
      boot(1'b1, 1'b1);
      rdc(OFS_STATUS, 32'h1F, 32'h19);
      wr(OFS_CRED, 32'h0);
      cmd(16'h01F2, 1'b1);
      cmd(16'h00C8, 1'b1);
      cmd(16'h00F3, 1'b0);
      cmd(16'h01F4, 1'b0);
      chk({31'h0, erased}, 32'h1);
      rdc(OFS_STATUS, 32'h07, 32'h02);
      $display("test max level done");
      boot(1'b0, 1'b0);
      rdc(OFS_STATUS, 32'h1F, 32'h02);
      rdc(OFS_REV, 32'hFFFF, 32'hFFFE);
      rdc(OFS_IRQ_MASK, 32'h7, 32'h0);
      host.xfer(1'b0, 8'h40, 32'h0, q, e);
      chk({q[30:0], e}, 32'h1);
      rdc(OFS_IRQ_STAT, 32'h7, 32'h0);
      cmd(16'h14B0, 1'b1);
      chk({31'h0, irq}, 32'h0);
      rdc(OFS_IRQ_STAT, 32'h7, 32'h3);
      wr(OFS_IRQ_MASK, 32'h2);
      cmd(16'h14B0, 1'b1);
      chk({31'h0, irq}, 32'h1);
      rdc(OFS_IRQ_STAT, 32'h7, 32'h3);
      repeat (2) @(negedge ref_clk);
      chk({31'h0, irq}, 32'h0);
      $display("test interrupt done");
      // Master programmed before any user credential
      wr(OFS_CRED, 32'h12345678);
      wr(OFS_REV, 32'h0042);
      cmd(16'h01F1, 1'b0);
      rdc(OFS_STATUS, 32'h1F, 32'h02);
      rdc(OFS_REV, 32'hFFFF, 32'h0042);
      wr(OFS_CRED, 32'hA5A50001);
      cmd(16'h00F1, 1'b0);
      rdc(OFS_STATUS, 32'h1F, 32'h0A);
      pulse_hard();
      rdc(OFS_STATUS, 32'h1F, 32'h09);
      foreach (LOCK_T[i]) cmd(LOCK_T[i][15:0], LOCK_T[i][16]);
      wr(OFS_CRED, 32'h0BAD0BAD);
      for (int i = 0; i < 4; i++) cmd({7'h0, i[0], 8'hF2}, 1'b1);
      rdc(OFS_STATUS, 32'h1FF, 32'h89);
      wr(OFS_CRED, 32'h12345678);
      cmd(16'h01F2, 1'b0);
      rdc(OFS_STATUS, 32'h1FF, 32'h8A);
      foreach (UNL_T[i]) cmd(UNL_T[i][15:0], UNL_T[i][16]);
      wr(OFS_CRED, 32'h0BAD0BAD);
      cmd(16'h00F2, 1'b1);
      rdc(OFS_WORD128, 32'h10, 32'h10);
      wr(OFS_CRED, 32'h12345678);
      cmd(16'h01F2, 1'b1);
      cmd(16'h00F3, 1'b0);
      cmd(16'h01F4, 1'b1);
      chk({31'h0, erased}, 32'h0);
      pulse_hard();
      rdc(OFS_STATUS, 32'h1FF, 32'h09);
      $display("test locked mode done");
      wr(OFS_CRED, 32'hA5A50001);
      cmd(16'h00F2, 1'b0);
      cmd(16'h00F5, 1'b0);
      rdc(OFS_STATUS, 32'h1F, 32'h0C);
      foreach (FRZ_T[i]) cmd(FRZ_T[i][15:0], FRZ_T[i][16]);
      pulse_hard();
      rdc(OFS_STATUS, 32'h07, 32'h04);
      $display("test frozen mode done");
      boot(1'b1, 1'b0);
      wr(OFS_CRED, 32'hA5A50001);
      cmd(16'h00F2, 1'b0);
      cmd(16'h00F6, 1'b0);
      rdc(OFS_STATUS, 32'h1F, 32'h02);
      $display("test disable done");
      close_out();
   end
endmodule

// ---- verilog/pwl_cred_mem.sv ----
// Two-entry credential store with registered read data
module pwl_cred_mem #(
   parameter int WIDTH = 32
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Write port
   input wire logic we,
   input wire logic waddr,
   input wire logic [WIDTH-1:0] wdata,
   // Read port
   input wire logic raddr,
   output logic [WIDTH-1:0] rdata
);
   // Array has no reset: it models retained storage
   logic [WIDTH-1:0] mem [0:1];

   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= '0;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule

// ---- verilog/pwl_lock_gate.sv ----
// Credential lock and command gate with APB register access
// Contract
// - High level, armed: matching master credential on unlock leaves locked mode.
// - Maximum level: master unlock refused; only secure-erase with master unlocks, erasing data.
// - Storing master credential never arms locking; master only unlocks.
// - Report master revision code in word 92; valid 0001h-FFFEh, default FFFEh.
// - Setting user credential arms locking for next power-on or hard reset.
// - Armed at power-on: abort media access until unlock succeeds.
// - One shared mismatch counter for master and user comparison failures.
// - At five mismatches set expiry flag bit 4 word 128; abort unlock, erase.
// - Only power-on or hard reset clears mismatch counter and expiry flag.
// - Locked mode aborts media, flush, format, config, freeze, credential and most transport commands.
// - Locked mode still executes identify, diagnostics, buffers, seek, erase, unlock and others.
// - Frozen aborts disable, erase-prepare, secure-erase, set-credential, unlock; else as unlocked.
// - Long sector transport command always aborted; unlocked mode executes everything else.
// - Set-credential replaces default master credential while staying disarmed.
// - Frozen mode holds until power removal; no hard reset or command releases it.
// - Locked mode leaves only by successful unlock or secure-erase.
// - No user credential stored: unlocked mode directly after power-on.
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
module pwl_lock_gate
   import pwl_pkg::*;
#(
   parameter int CRED_WIDTH = 32,
   parameter logic [31:0] DEFAULT_MASTER = 32'h0000_0000
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Retained settings sampled after power-on
   input wire logic nvUserSet,
   input wire logic nvLevelMax,
   // Hard reset request, one-cycle pulse
   input wire logic hardReset,
   // Command results and interrupt
   output logic cmdDone,
   output logic cmdAborted,
   output logic eraseStart,
   output logic irq
);
   typedef struct packed {
      pwl_mode_t mode;
      pwl_state_t fsm;
      logic booted;
      logic [7:0] op;
      logic useMaster;
      logic levelReq;
      logic sct;
      logic [3:0] sctAct;
      logic [31:0] cred;
      logic [15:0] revIn;
      logic [15:0] revision;
      logic armed;
      logic levelMax;
      logic masterValid;
      logic [2:0] mismatch;
      logic expired;
      logic prepared;
      logic lastAbort;
      logic [2:0] irqStat;
      logic [2:0] irqMask;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
      logic done;
      logic aborted;
      logic erase;
   } pwl_regs_t;

   pwl_regs_t s;
   pwl_regs_t next_s;
   logic memWe;
   logic memWaddr;
   logic [CRED_WIDTH-1:0] memWdata;
   logic memRaddr;
   logic [CRED_WIDTH-1:0] memRdata;

   pwl_cred_mem #(
      .WIDTH(CRED_WIDTH)
   ) u_mem (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .we(memWe),
      .waddr(memWaddr),
      .wdata(memWdata),
      .raddr(memRaddr),
      .rdata(memRdata)
   );

   always_comb begin
      logic access;
      logic prep;
      logic abort;
      logic credOk;
      logic miss;
      logic [2:0] setIrq;
      logic [2:0] clrIrq;
      logic [31:0] rd;
      logic hit;
      access = psel & penable & s.pready;
      prep = psel & penable & !s.pready;
      abort = 1'b0;
      miss = 1'b0;
      setIrq = 3'h0;
      clrIrq = 3'h0;
      rd = 32'h0000_0000;
      hit = 1'b1;
      if (s.useMaster && !s.masterValid) begin
         credOk = (s.cred[CRED_WIDTH-1:0] == DEFAULT_MASTER[CRED_WIDTH-1:0]);
      end else begin
         credOk = (memRdata == s.cred[CRED_WIDTH-1:0]);
      end
      next_s = s;
      next_s.done = 1'b0;
      next_s.aborted = 1'b0;
      next_s.erase = 1'b0;
      memWe = 1'b0;
      memWaddr = CRED_USER;
      memWdata = s.cred[CRED_WIDTH-1:0];
      // Store read is registered, so the compare waits for the check state
      memRaddr = s.useMaster;

      if (!s.booted) begin
         // Boot runs once, one edge after rst_n rises
         next_s.booted = 1'b1;
         next_s.armed = nvUserSet;
         next_s.levelMax = nvLevelMax;
         next_s.mode = nvUserSet ? MODE_LOCKED : MODE_UNLOCKED;
      end

      // Read data is staged one cycle ahead so prdata comes from a flop
      next_s.pready = prep;
      // Error flag stands only beside pready, never past the transfer
      next_s.pslverr = 1'b0;
      if (prep) begin
         unique case (paddr)
            OFS_CMD: rd = {16'h0000,
                           s.sctAct,
                           1'b0,
                           s.sct,
                           s.levelReq,
                           s.useMaster,
                           s.op};
            OFS_CRED: rd = s.cred;
            OFS_REV: rd = {16'h0000, s.revision};
            OFS_STATUS: rd = {s.revision,
                              4'h0,
                              s.masterValid,
                              s.lastAbort,
                              !s.fsm[0],
                              s.expired,
                              s.mismatch,
                              s.levelMax,
                              s.armed,
                              s.mode};
            OFS_IRQ_STAT: rd = {29'h0, s.irqStat};
            OFS_IRQ_MASK: rd = {29'h0, s.irqMask};
            OFS_WORD128: rd = {26'h0,
                               s.levelMax,
                               s.expired,
                               s.mode == MODE_FROZEN,
                               s.mode == MODE_LOCKED,
                               s.armed,
                               1'b1};
            default: hit = 1'b0;
         endcase
         next_s.prdata = rd;
         next_s.pslverr = !hit;
      end
      if (access && !pwrite && paddr == OFS_IRQ_STAT) begin
         // Clear only what was shown, so a later event survives
         clrIrq = s.prdata[2:0];
      end
      if (access && pwrite) begin
         unique case (paddr)
            OFS_CMD: begin
               // Commands while busy or before boot are dropped
               if (s.fsm == ST_IDLE && s.booted) begin
                  next_s.op = pwdata[7:0];
                  next_s.useMaster = pwdata[CMD_USE_MASTER];
                  next_s.levelReq = pwdata[CMD_LEVEL_MAX];
                  next_s.sct = pwdata[CMD_SCT];
                  next_s.sctAct = pwdata[CMD_SCT_ACT_LSB +: 4];
                  next_s.fsm = ST_FETCH;
               end
            end
            OFS_CRED: next_s.cred = pwdata;
            OFS_REV: next_s.revIn = pwdata[15:0];
            OFS_IRQ_MASK: next_s.irqMask = pwdata[2:0];
            default: ;
         endcase
      end

      unique case (s.fsm)
         ST_IDLE: ;
         ST_FETCH: next_s.fsm = ST_CHECK;
         ST_CHECK: begin
            next_s.fsm = ST_IDLE;
            if (s.sct && s.sctAct == SCT_LONG_RW) begin
               abort = 1'b1;
            end else if (s.mode == MODE_LOCKED && lockedAbort(s.op, s.sct, s.sctAct)) begin
               abort = 1'b1;
            end else if (s.mode == MODE_FROZEN && frozenAbort(s.op, s.sct)) begin
               abort = 1'b1;
            end else if (!s.sct) begin
               unique case (s.op)
                  OP_UNLOCK: begin
                     if (s.expired) begin
                        abort = 1'b1;
                     // master unlock refused at maximum level
                     end else if (s.useMaster && s.levelMax && s.armed) begin
                        abort = 1'b1;
                     end else if (credOk) begin
                        if (s.mode == MODE_LOCKED) begin
                           next_s.mode = MODE_UNLOCKED;
                        end
                     end else begin
                        abort = 1'b1;
                        miss = 1'b1;
                     end
                  end
                  OP_ERASE_UNIT: begin
                     if (s.expired || !s.prepared) begin
                        abort = 1'b1;
                     end else if (credOk) begin
                        next_s.erase = 1'b1;
                        next_s.mode = MODE_UNLOCKED;
                        next_s.armed = 1'b0;
                        next_s.levelMax = 1'b0;
                     end else begin
                        abort = 1'b1;
                        miss = 1'b1;
                     end
                  end
                  OP_SET_CRED: begin
                     memWe = 1'b1;
                     if (s.useMaster) begin
                        memWaddr = CRED_MASTER;
                        next_s.masterValid = 1'b1;
                        if (s.revIn >= REV_MIN && s.revIn <= REV_MAX) begin
                           next_s.revision = s.revIn;
                        end
                     end else begin
                        memWaddr = CRED_USER;
                        next_s.armed = 1'b1;
                        next_s.levelMax = s.levelReq;
                     end
                  end
                  OP_DISABLE_CRED: begin
                     if (credOk && !(s.useMaster && s.levelMax)) begin
                        next_s.armed = 1'b0;
                     end else begin
                        abort = 1'b1;
                        miss = !credOk;
                     end
                  end
                  OP_FREEZE: next_s.mode = MODE_FROZEN;
                  default: ;
               endcase
            end
            // nothing here ever lowers the counter
            if (miss && s.mismatch < MAX_TRIES) begin
               next_s.mismatch = s.mismatch + 3'h1;
               if (s.mismatch + 3'h1 == MAX_TRIES) begin
                  next_s.expired = 1'b1;
                  setIrq[IRQ_EXPIRY] = 1'b1;
               end
            end
            next_s.prepared = !s.sct && s.op == OP_ERASE_PREP && !abort;
            next_s.done = 1'b1;
            next_s.aborted = abort;
            next_s.lastAbort = abort;
            setIrq[IRQ_DONE] = 1'b1;
            setIrq[IRQ_ABORT] = abort;
         end
         default: next_s.fsm = ST_IDLE;
      endcase

      // hard reset clears counter and flag
      if (hardReset && s.booted) begin
         next_s.mismatch = 3'h0;
         next_s.expired = 1'b0;
         // An erase-prepare does not survive a hard reset
         next_s.prepared = 1'b0;
         if (s.mode != MODE_FROZEN) begin
            next_s.mode = next_s.armed ? MODE_LOCKED : MODE_UNLOCKED;
         end
      end

      // Set wins over read-clear
      next_s.irqStat = (s.irqStat & ~clrIrq) | setIrq;
      next_s.irq = |(next_s.irqStat & next_s.irqMask);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '{mode: MODE_UNLOCKED, fsm: ST_IDLE, revision: REV_DEFAULT, irqMask: IRQ_MASK_RESET,
                default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign cmdDone = s.done;
   assign cmdAborted = s.aborted;
   assign eraseStart = s.erase;
   assign irq = s.irq;
endmodule

// ---- verilog/pwl_pkg.sv ----
// Constants, types and command classification for the credential lock gate
package pwl_pkg;
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_CRED = 8'h04;
   localparam logic [7:0] OFS_REV = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFS_WORD128 = 8'h18;
   localparam int CMD_USE_MASTER = 8;
   localparam int CMD_LEVEL_MAX = 9;
   localparam int CMD_SCT = 10;
   localparam int CMD_SCT_ACT_LSB = 12;
   localparam int W128_EXPIRY_BIT = 4;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ABORT = 1;
   localparam int IRQ_EXPIRY = 2;
   localparam logic [2:0] MAX_TRIES = 3'h5;
   localparam logic [15:0] REV_DEFAULT = 16'hFFFE;
   localparam logic [15:0] REV_MIN = 16'h0001;
   localparam logic [15:0] REV_MAX = 16'hFFFE;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
   localparam logic CRED_USER = 1'b0;
   localparam logic CRED_MASTER = 1'b1;
   // Security command opcodes
   localparam logic [7:0] OP_SET_CRED = 8'hF1;
   localparam logic [7:0] OP_UNLOCK = 8'hF2;
   localparam logic [7:0] OP_ERASE_PREP = 8'hF3;
   localparam logic [7:0] OP_ERASE_UNIT = 8'hF4;
   localparam logic [7:0] OP_FREEZE = 8'hF5;
   localparam logic [7:0] OP_DISABLE_CRED = 8'hF6;
   localparam logic [7:0] OP_SET_MAX = 8'hF9;
   // Transport-extension action codes
   localparam logic [3:0] SCT_READ_STATUS = 4'h0;
   localparam logic [3:0] SCT_LONG_RW = 4'h1;

   typedef enum logic [2:0] {
      MODE_LOCKED = 3'b001,
      MODE_UNLOCKED = 3'b010,
      MODE_FROZEN = 3'b100
   } pwl_mode_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_FETCH = 3'b010,
      ST_CHECK = 3'b100
   } pwl_state_t;

   // Commands refused while locked; everything not listed stays executable
   function automatic logic lockedAbort(input logic [7:0] op, input logic sct, input logic [3:0] act);
      logic hit;
      hit = 1'b0;
      if (sct) begin
         hit = (act != SCT_READ_STATUS);
      end else begin
         unique case (op)
            8'hC8, 8'h25, 8'h60, 8'hC4, 8'h29, 8'h20, 8'h24, 8'h2A, 8'h2B, 8'h40, 8'h42,
            8'hCA, 8'h35, 8'h3D, 8'h61, 8'hC5, 8'h39, 8'hCE, 8'h30, 8'h34, 8'h3A, 8'h3B,
            8'h45, 8'h3F, 8'hE7, 8'hEA, 8'h50, 8'h92, OP_SET_MAX, 8'h37, 8'h51, 8'hB1,
            OP_DISABLE_CRED, OP_FREEZE, OP_SET_CRED: hit = 1'b1;
            default: hit = 1'b0;
         endcase
      end
      return hit;
   endfunction

   // Commands refused while frozen
   function automatic logic frozenAbort(input logic [7:0] op, input logic sct);
      return !sct && (op == OP_DISABLE_CRED || op == OP_ERASE_PREP || op == OP_ERASE_UNIT ||
                      op == OP_SET_CRED || op == OP_UNLOCK);
   endfunction
endpackage
